// File: adcsq_pkg.sv
// constants, register map and types of the conversion sequencer
package adcsq_pkg;

	// register word addresses (byte offsets)
	localparam logic [5:0] ADDR_CTRL1   = 6'h00;
	localparam logic [5:0] ADDR_CTRL2   = 6'h04;
	localparam logic [5:0] ADDR_STS     = 6'h08;
	localparam logic [5:0] ADDR_WDLIM   = 6'h0C;
	localparam logic [5:0] ADDR_SEQLEN  = 6'h10;
	localparam logic [5:0] ADDR_RSEQ_LO = 6'h14;
	localparam logic [5:0] ADDR_RSEQ_HI = 6'h18;
	localparam logic [5:0] ADDR_JSEQ    = 6'h1C;
	localparam logic [5:0] ADDR_JOFF_LO = 6'h20;
	localparam logic [5:0] ADDR_JOFF_HI = 6'h24;
	localparam logic [5:0] ADDR_RDATA   = 6'h28;
	localparam logic [5:0] ADDR_JDATA0  = 6'h2C;
	localparam logic [5:0] ADDR_JDATA1  = 6'h30;
	localparam logic [5:0] ADDR_JDATA2  = 6'h34;
	localparam logic [5:0] ADDR_JDATA3  = 6'h38;

	// status bit positions
	localparam int STS_REG_END = 0;
	localparam int STS_INJ_END = 1;
	localparam int STS_WD      = 2;
	localparam int STS_POWERED = 3;
	localparam int STS_BUSY    = 4;

	// field positions inside the limit, length and offset registers
	localparam int WD_HIGH_LSB = 0;
	localparam int WD_LOW_LSB  = 16;
	localparam int RLEN_LSB    = 0;
	localparam int JLEN_LSB    = 4;
	localparam int JOFF_B_LSB  = 16;

	// reset values
	localparam logic [11:0] WD_HIGH_RST = 12'hFFF;
	localparam logic [11:0] WD_LOW_RST  = 12'h000;

	// timing in converter cycles
	localparam logic [3:0] CONV_CYCLES = 4'hE;
	localparam logic [1:0] GAP_PRESC2  = 2'h2;
	localparam logic [1:0] GAP_PRESC48 = 2'h1;

	// control word 1, lsb last
	typedef struct packed {
		logic       wd_irq_en;
		logic       inj_end_irq_en;
		logic       reg_end_irq_en;
		logic [3:0] wd_channel_sel;
		logic       wd_inject_en;
		logic       wd_regular_en;
		logic       wd_single_channel;
		logic [2:0] discont_count;
		logic       inj_discont_en;
		logic       reg_discont_en;
		logic       auto_inject_en;
		logic       scan_en;
	} adcsq_ctrl1_t;

	// control word 2, lsb last
	typedef struct packed {
		logic presc_long;
		logic inj_trig_en;
		logic reg_trig_en;
		logic align_left;
		logic dma_req_en;
		logic continuous_select;
		logic on;
	} adcsq_ctrl2_t;

	// sequencer states, gray along idle -> conv -> gap
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_CONV = 2'h1,
		ST_GAP  = 2'h3
	} adcsq_state_t;

endpackage

// File: adcsq_top.sv
// conversion sequencer: modes, injection, watchdog, alignment, registers
//
// The register offsets and the address-and-strobe port were decided locally.
`timescale 1ns/10ps
module adcsq_top
	import adcsq_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        nrst,
	input  wire logic [5:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	input  wire logic        ext_reg_trig,
	input  wire logic        ext_inj_trig,
	input  wire logic [11:0] conv_data,
	output logic             adc_power_on,
	output logic             conv_start,
	output logic      [3:0]  conv_channel,
	output logic             dma_req,
	output logic             reg_end_irq,
	output logic             inj_end_irq,
	output logic             wd_irq
);

	adcsq_ctrl1_t        ctrl1_ff;
	adcsq_ctrl2_t        ctrl2_ff;
	logic [11:0]         wd_high_limit_ff, wd_low_limit_ff;
	logic [3:0]          reg_seq_length_ff;
	logic [1:0]          inj_seq_length_ff;
	logic [15:0][3:0]    reg_seq_cfg_ff;
	logic [3:0][3:0]     inj_seq_cfg_ff;
	logic [3:0][11:0]    inj_offset_ff;
	logic [15:0]         reg_result_ff;
	logic [3:0][15:0]    inj_result_ff;
	logic                reg_end_flag_ff, inj_end_flag_ff, wd_flag_ff;
	logic                powered_ff;
	logic [31:0]         rdata_ff;
	logic                dma_req_ff, reg_irq_ff, inj_irq_ff, wd_irq_ff;
	logic [1:0]          s1_ff, s2_ff, s3_ff, lvl_ff, trig_edge, trig_pin;
	adcsq_state_t        st_ff;
	logic [3:0]          cnt_ff, reg_idx_ff, burst_ff, conv_channel_ff;
	logic [1:0]          inj_idx_ff, gap_ff;
	logic                cur_inj_ff, reg_act_ff, inj_act_ff, reg_pend_ff;
	logic                conv_start_ff;
	logic                conv_done, last_r, last_j, wr_on, reg_go, inj_go;
	logic                wd_cover, wd_hit, launch;
	logic [12:0]         inj_diff;
	logic [15:0]         reg_aligned, inj_aligned;
	logic [3:0]          burst_init;
	logic [1:0]          gap_len;

	assign reg_rdata    = rdata_ff;
	assign adc_power_on = powered_ff;
	assign conv_start   = conv_start_ff;
	assign conv_channel = conv_channel_ff;
	assign dma_req      = dma_req_ff;
	assign reg_end_irq  = reg_irq_ff;
	assign inj_end_irq  = inj_irq_ff;
	assign wd_irq       = wd_irq_ff;

	// trigger pins: three flops, a level counts once stages two and three agree
	assign trig_pin = {ext_inj_trig, ext_reg_trig};
	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1) begin : g_sync
			always_ff @(posedge mclk) begin
				if (!nrst) begin
					s1_ff[g]  <= 1'b0;
					s2_ff[g]  <= 1'b0;
					s3_ff[g]  <= 1'b0;
					lvl_ff[g] <= 1'b0;
				end else begin
					s1_ff[g] <= trig_pin[g];
					s2_ff[g] <= s1_ff[g];
					s3_ff[g] <= s2_ff[g];
					if (s2_ff[g] == s3_ff[g])
						lvl_ff[g] <= s3_ff[g];
				end
			end
			// rising edge of the filtered level
			assign trig_edge[g] = (s2_ff[g] == s3_ff[g]) && s3_ff[g] &&
				!lvl_ff[g];
		end
	endgenerate

	// start decode; a start while off or unpowered is dropped
	assign wr_on  = reg_wr && (reg_addr == ADDR_CTRL2) && reg_wdata[0];
	assign reg_go = powered_ff && ((wr_on && ctrl2_ff.on) ||
		(trig_edge[0] && ctrl2_ff.reg_trig_en));
	// auto injection ignores the injected trigger entirely
	assign inj_go = powered_ff && trig_edge[1] && ctrl2_ff.inj_trig_en &&
		!ctrl1_ff.auto_inject_en;
	assign conv_done = (st_ff == ST_CONV) && (cnt_ff == CONV_CYCLES - 4'h1);
	// without scan only the first slot of a sequence is converted
	assign last_r = !ctrl1_ff.scan_en ||
		(reg_idx_ff == reg_seq_length_ff);
	assign last_j = !ctrl1_ff.scan_en || (inj_idx_ff == inj_seq_length_ff);
	assign launch = (st_ff == ST_IDLE) && (inj_act_ff || reg_act_ff) &&
		ctrl2_ff.on;
	assign burst_init = {1'b0, ctrl1_ff.discont_count} + 4'h1;
	assign gap_len = ctrl2_ff.presc_long ? GAP_PRESC48 : GAP_PRESC2;

	// sequencer: launch, count, decide the next slot
	always_ff @(posedge mclk) begin
		if (!nrst || !ctrl2_ff.on) begin
			st_ff           <= ST_IDLE;
			cnt_ff          <= 4'h0;
			gap_ff          <= 2'h0;
			reg_idx_ff      <= 4'h0;
			inj_idx_ff      <= 2'h0;
			burst_ff        <= 4'h0;
			cur_inj_ff      <= 1'b0;
			reg_act_ff      <= 1'b0;
			inj_act_ff      <= 1'b0;
			reg_pend_ff     <= 1'b0;
			conv_start_ff   <= 1'b0;
			conv_channel_ff <= 4'h0;
		end else begin
			conv_start_ff <= launch;
			case (st_ff)
				ST_IDLE: begin
					if (launch) begin
						// injected work always goes first
						cur_inj_ff      <= inj_act_ff;
						conv_channel_ff <= inj_act_ff ?
							inj_seq_cfg_ff[inj_idx_ff] :
							reg_seq_cfg_ff[reg_idx_ff];
						cnt_ff <= 4'h0;
						st_ff  <= ST_CONV;
					end
				end
				ST_CONV: begin
					cnt_ff <= cnt_ff + 4'h1;
					if (conv_done) begin
						st_ff <= ST_IDLE;
						if (!cur_inj_ff) begin
							if (ctrl1_ff.reg_discont_en) begin
								burst_ff   <= burst_ff - 4'h1;
								reg_idx_ff <= last_r ? 4'h0 :
									reg_idx_ff + 4'h1;
								reg_act_ff <= !last_r &&
									(burst_ff != 4'h1);
							end else if (last_r) begin
								reg_idx_ff <= 4'h0;
								reg_act_ff <=
									ctrl2_ff.continuous_select;
								if (ctrl1_ff.auto_inject_en) begin
									inj_act_ff <= 1'b1;
									inj_idx_ff <= 2'h0;
									gap_ff     <= gap_len;
									st_ff      <= ST_GAP;
								end
							end else begin
								reg_idx_ff <= reg_idx_ff + 4'h1;
							end
						end else begin
							inj_idx_ff <= last_j ? 2'h0 : inj_idx_ff + 2'h1;
							// one slot per trigger in discontinuous mode
							inj_act_ff <= !last_j &&
								!ctrl1_ff.inj_discont_en;
							if (last_j && ctrl1_ff.auto_inject_en &&
								reg_act_ff) begin
								gap_ff <= gap_len;
								st_ff  <= ST_GAP;
							end
							// a held regular start runs now
							if (last_j && reg_pend_ff) begin
								reg_pend_ff <= 1'b0;
								reg_act_ff  <= 1'b1;
								burst_ff    <= burst_init;
								if (!ctrl1_ff.reg_discont_en)
									reg_idx_ff <= 4'h0;
							end
						end
					end else if (inj_go && !cur_inj_ff) begin
						// abandon this slot; its index is kept for resume
						st_ff <= ST_IDLE;
					end
				end
				ST_GAP: begin
					gap_ff <= gap_ff - 2'h1;
					if (gap_ff == 2'h1)
						st_ff <= ST_IDLE;
				end
				default: st_ff <= ST_IDLE;
			endcase
			// triggers; injected starts never repeat on their own
			if (inj_go && !inj_act_ff) begin
				inj_act_ff <= 1'b1;
				if (!ctrl1_ff.inj_discont_en)
					inj_idx_ff <= 2'h0;
			end
			if (reg_go && !reg_act_ff) begin
				// an injected sequence ending this cycle does not hold it
				if ((inj_act_ff && !(conv_done && cur_inj_ff && last_j)) ||
					inj_go) begin
					reg_pend_ff <= 1'b1;
				end else begin
					reg_act_ff <= 1'b1;
					burst_ff   <= burst_init;
					if (!ctrl1_ff.reg_discont_en)
						reg_idx_ff <= 4'h0;
				end
			end
		end
	end

	// result formatting; watchdog sees the raw value
	assign inj_diff = {1'b0, conv_data} -
		{1'b0, inj_offset_ff[inj_idx_ff]};
	assign reg_aligned = ctrl2_ff.align_left ? {conv_data, 4'h0} :
		{4'h0, conv_data};
	assign inj_aligned = ctrl2_ff.align_left ?
		{inj_diff[12], inj_diff[11:0], 3'h0} :
		{{4{inj_diff[12]}}, inj_diff[11:0]};
	assign wd_cover = (cur_inj_ff ? ctrl1_ff.wd_inject_en :
		ctrl1_ff.wd_regular_en) && (!ctrl1_ff.wd_single_channel ||
		conv_channel_ff == ctrl1_ff.wd_channel_sel);
	assign wd_hit = wd_cover && ((conv_data > wd_high_limit_ff) ||
		(conv_data < wd_low_limit_ff));

	// results and flags; a set in the clearing cycle wins
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			reg_result_ff   <= 16'h0000;
			inj_result_ff   <= '0;
			reg_end_flag_ff <= 1'b0;
			inj_end_flag_ff <= 1'b0;
			wd_flag_ff      <= 1'b0;
			dma_req_ff      <= 1'b0;
		end else begin
			dma_req_ff <= conv_done && !cur_inj_ff &&
				ctrl2_ff.dma_req_en;
			if (reg_wr && reg_addr == ADDR_STS) begin
				if (reg_wdata[STS_REG_END]) reg_end_flag_ff <= 1'b0;
				if (reg_wdata[STS_INJ_END]) inj_end_flag_ff <= 1'b0;
				if (reg_wdata[STS_WD])      wd_flag_ff      <= 1'b0;
			end
			if (conv_done && !cur_inj_ff) begin
				reg_result_ff   <= reg_aligned;
				reg_end_flag_ff <= 1'b1;
			end
			if (conv_done && cur_inj_ff) begin
				inj_result_ff[inj_idx_ff] <= inj_aligned;
				if (!ctrl1_ff.inj_discont_en || last_j)
					inj_end_flag_ff <= 1'b1;
			end
			if (conv_done && wd_hit)
				wd_flag_ff <= 1'b1;
		end
	end

	// interrupt lines follow flag and enable, one cycle behind
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			reg_irq_ff <= 1'b0;
			inj_irq_ff <= 1'b0;
			wd_irq_ff  <= 1'b0;
		end else begin
			reg_irq_ff <= reg_end_flag_ff && ctrl1_ff.reg_end_irq_en;
			inj_irq_ff <= inj_end_flag_ff && ctrl1_ff.inj_end_irq_en;
			wd_irq_ff  <= wd_flag_ff && ctrl1_ff.wd_irq_en;
		end
	end

	// register writes; sequences should only change while idle
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			ctrl1_ff          <= '0;
			ctrl2_ff          <= '0;
			powered_ff        <= 1'b0;
			wd_high_limit_ff  <= WD_HIGH_RST;
			wd_low_limit_ff   <= WD_LOW_RST;
			reg_seq_length_ff <= 4'h0;
			inj_seq_length_ff <= 2'h0;
			reg_seq_cfg_ff    <= '0;
			inj_seq_cfg_ff    <= '0;
			inj_offset_ff     <= '0;
		end else if (reg_wr) begin
			case (reg_addr)
				ADDR_CTRL1: ctrl1_ff <= adcsq_ctrl1_t'(reg_wdata[16:0]);
				ADDR_CTRL2: begin
					ctrl2_ff <= adcsq_ctrl2_t'(reg_wdata[6:0]);
					// first on only powers up; clearing on powers down
					powered_ff <= reg_wdata[0];
				end
				ADDR_WDLIM: begin
					wd_high_limit_ff <= reg_wdata[WD_HIGH_LSB +: 12];
					wd_low_limit_ff  <= reg_wdata[WD_LOW_LSB +: 12];
				end
				ADDR_SEQLEN: begin
					reg_seq_length_ff <= reg_wdata[RLEN_LSB +: 4];
					inj_seq_length_ff <= reg_wdata[JLEN_LSB +: 2];
				end
				ADDR_RSEQ_LO: reg_seq_cfg_ff[7:0]  <= reg_wdata;
				ADDR_RSEQ_HI: reg_seq_cfg_ff[15:8] <= reg_wdata;
				ADDR_JSEQ:    inj_seq_cfg_ff       <= reg_wdata[15:0];
				ADDR_JOFF_LO: begin
					inj_offset_ff[0] <= reg_wdata[11:0];
					inj_offset_ff[1] <= reg_wdata[JOFF_B_LSB +: 12];
				end
				ADDR_JOFF_HI: begin
					inj_offset_ff[2] <= reg_wdata[11:0];
					inj_offset_ff[3] <= reg_wdata[JOFF_B_LSB +: 12];
				end
				default: ;
			endcase
		end
	end

	// read data stands only in the cycle after the read strobe
	always_ff @(posedge mclk) begin
		if (!nrst || !reg_rd) begin
			rdata_ff <= 32'h0000_0000;
		end else begin
			case (reg_addr)
				ADDR_CTRL1:   rdata_ff <= {15'h0000, ctrl1_ff};
				ADDR_CTRL2:   rdata_ff <= {25'h0000000, ctrl2_ff};
				ADDR_STS:     rdata_ff <= {27'h0000000,
					st_ff != ST_IDLE || reg_act_ff || inj_act_ff,
					powered_ff, wd_flag_ff, inj_end_flag_ff,
					reg_end_flag_ff};
				ADDR_WDLIM:   rdata_ff <= {4'h0, wd_low_limit_ff,
					4'h0, wd_high_limit_ff};
				ADDR_SEQLEN:  rdata_ff <= {26'h0000000,
					inj_seq_length_ff, reg_seq_length_ff};
				ADDR_RSEQ_LO: rdata_ff <= reg_seq_cfg_ff[7:0];
				ADDR_RSEQ_HI: rdata_ff <= reg_seq_cfg_ff[15:8];
				ADDR_JSEQ:    rdata_ff <= {16'h0000, inj_seq_cfg_ff};
				ADDR_JOFF_LO: rdata_ff <= {4'h0, inj_offset_ff[1],
					4'h0, inj_offset_ff[0]};
				ADDR_JOFF_HI: rdata_ff <= {4'h0, inj_offset_ff[3],
					4'h0, inj_offset_ff[2]};
				ADDR_RDATA:   rdata_ff <= {16'h0000, reg_result_ff};
				ADDR_JDATA0:  rdata_ff <= {16'h0000, inj_result_ff[0]};
				ADDR_JDATA1:  rdata_ff <= {16'h0000, inj_result_ff[1]};
				ADDR_JDATA2:  rdata_ff <= {16'h0000, inj_result_ff[2]};
				ADDR_JDATA3:  rdata_ff <= {16'h0000, inj_result_ff[3]};
				default:      rdata_ff <= 32'h0000_0000;
			endcase
		end
	end

	// checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);

	sequence s_reg_done;
		conv_done && !cur_inj_ff;
	endsequence
	sequence s_inj_done;
		conv_done && cur_inj_ff;
	endsequence

	property p_conv_len;
		conv_done |-> $past(conv_start_ff, 13);
	endproperty
	a_conv_len: assert property (p_conv_len)
		else $error("conversion did not last 14 cycles");

	property p_reg_flag;
		s_reg_done |=> reg_end_flag_ff && reg_result_ff == $past(reg_aligned);
	endproperty
	a_reg_flag: assert property (p_reg_flag)
		else $error("regular completion not recorded");

	property p_inj_flag;
		s_inj_done ##0 !ctrl1_ff.inj_discont_en |=> inj_end_flag_ff;
	endproperty
	a_inj_flag: assert property (p_inj_flag)
		else $error("injected end flag missing");

	property p_irq;
		reg_end_flag_ff && ctrl1_ff.reg_end_irq_en |=> reg_irq_ff;
	endproperty
	a_irq: assert property (p_irq)
		else $error("regular end interrupt missing");

	property p_wd;
		conv_done && wd_hit |=> wd_flag_ff;
	endproperty
	a_wd: assert property (p_wd)
		else $error("watchdog flag missing");

	property p_dma;
		s_reg_done ##0 ctrl2_ff.dma_req_en |=> dma_req_ff ##1 !dma_req_ff;
	endproperty
	a_dma: assert property (p_dma)
		else $error("dma request not a single pulse");

	property p_single;
		s_reg_done ##0 (!ctrl2_ff.continuous_select && !ctrl1_ff.scan_en &&
			!ctrl1_ff.auto_inject_en && !inj_act_ff && !reg_pend_ff &&
			!reg_go && !inj_go) |=> !reg_act_ff ##1 !conv_start_ff;
	endproperty
	a_single: assert property (p_single)
		else $error("single mode did not stop");

	property p_right;
		s_reg_done ##0 !ctrl2_ff.align_left |=> reg_result_ff[15:12] == 4'h0;
	endproperty
	a_right: assert property (p_right)
		else $error("right aligned regular result has upper bits");

	property p_gap;
		s_reg_done ##0 (last_r && ctrl1_ff.auto_inject_en &&
			!ctrl1_ff.reg_discont_en && !ctrl2_ff.presc_long) |=>
			(st_ff == ST_GAP)[*2] ##1 st_ff == ST_IDLE;
	endproperty
	a_gap: assert property (p_gap)
		else $error("auto injection gap wrong");

	property p_gap_long;
		s_reg_done ##0 (last_r && ctrl1_ff.auto_inject_en &&
			!ctrl1_ff.reg_discont_en && ctrl2_ff.presc_long) |=>
			st_ff == ST_GAP ##1 st_ff == ST_IDLE;
	endproperty
	a_gap_long: assert property (p_gap_long)
		else $error("auto injection single gap wrong");

endmodule

// File: adcsq_core_model.sv
// behavioural analog core: answers each conversion in its done cycle
`timescale 1ns/10ps
module adcsq_core_model
	import adcsq_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        nrst,
	input  wire logic        adc_power_on,
	input  wire logic        conv_start,
	input  wire logic [3:0]  conv_channel,
	input  wire logic [11:0] level,
	output logic      [11:0] conv_data
);
	logic [3:0]  cnt_ff;
	logic [11:0] noise_ff;

	// cycles since conv_start; an unpowered core never completes
	always_ff @(posedge mclk) begin
		if (!nrst || !adc_power_on) begin
			cnt_ff <= 4'h0;
		end else if (conv_start) begin
			cnt_ff <= 4'h1;
		end else if (cnt_ff == CONV_CYCLES - 4'h1) begin
			cnt_ff <= 4'h0;
		end else if (cnt_ff != 4'h0) begin
			cnt_ff <= cnt_ff + 4'h1;
		end
	end

	// changing junk outside the done cycle, so a late sample shows up
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			noise_ff <= 12'hA5C;
		end else begin
			noise_ff <= noise_ff + 12'h9B7;
		end
	end

	// the value depends on the channel so a wrong slot is visible
	assign conv_data = (cnt_ff == CONV_CYCLES - 4'h1) ?
		level + {8'h00, conv_channel} : noise_ff;
endmodule

// File: tb_adcsq_top.sv
// self-checking bench for the conversion sequencer
`timescale 1ns/10ps
module tb_adcsq_top
	import adcsq_pkg::*;
;
	logic               mclk;
	logic               nrst;
	logic        [5:0]  reg_addr;
	logic        [31:0] reg_wdata;
	logic               reg_wr;
	logic               reg_rd;
	logic        [31:0] reg_rdata;
	logic               ext_reg_trig;
	logic               ext_inj_trig;
	logic        [11:0] conv_data;
	logic               adc_power_on;
	logic               conv_start;
	logic        [3:0]  conv_channel;
	logic               dma_req;
	logic               reg_end_irq;
	logic               inj_end_irq;
	logic               wd_irq;
	logic        [11:0] lvl;
	logic        [31:0] rv;
	logic signed [15:0] ej;
	logic        [3:0]  chq [$];
	adcsq_ctrl1_t       c1;
	adcsq_ctrl2_t       c2;
	int                 n_errors;
	int                 total_checks;
	int                 n_dma;
	int                 n_cyc;
	int                 tq [$];
	// watchdog cases: value seen, {single, regular, channel}, flag
	logic        [11:0] wv [6] = '{12'h900, 12'h0F0, 12'h400, 12'h900,
		12'h900, 12'h900};
	logic        [5:0]  wc [6] = '{6'h10, 6'h10, 6'h10, 6'h00, 6'h35, 6'h36};
	logic               we [6] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};

	adcsq_top i_dut (.mclk(mclk), .nrst(nrst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .ext_reg_trig(ext_reg_trig),
		.ext_inj_trig(ext_inj_trig), .conv_data(conv_data),
		.adc_power_on(adc_power_on), .conv_start(conv_start),
		.conv_channel(conv_channel), .dma_req(dma_req),
		.reg_end_irq(reg_end_irq), .inj_end_irq(inj_end_irq),
		.wd_irq(wd_irq));

	adcsq_core_model i_core (.mclk(mclk), .nrst(nrst),
		.adc_power_on(adc_power_on), .conv_start(conv_start),
		.conv_channel(conv_channel), .level(lvl), .conv_data(conv_data));

	// 125 MHz clock
	initial mclk = 1'b0;
	always #4 mclk = ~mclk;

	// log every conversion start and dma pulse
	always @(posedge mclk) begin
		n_cyc++;
		if (conv_start === 1'b1) chq.push_back(conv_channel);
		if (conv_start === 1'b1) tq.push_back(n_cyc);
		if (dma_req === 1'b1) n_dma++;
	end

	task automatic chk(input string nm, input logic [31:0] seen, exp);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// compare the logged start order with packed four-bit slots
	task automatic chk_seq(input logic [19:0] exp, input int n);
		chk("start count", 32'(chq.size()), 32'(n));
		for (int q = 0; q < n; q++)
			chk("start slot", 32'(chq[q]), 32'(exp[4*q +: 4]));
	endtask

	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask

	// data stands only in the cycle after the strobe
	task automatic rd(input logic [5:0] a, output logic [31:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask

	// power off then on again, so the config write does not start
	task automatic cfg2(input adcsq_ctrl2_t c);
		wr(ADDR_CTRL2, 32'h0);
		wr(ADDR_CTRL2, 32'(c));
	endtask

	task automatic trig(input logic inj);
		@(posedge mclk);
		ext_inj_trig <= inj;
		ext_reg_trig <= !inj;
		repeat (3) @(posedge mclk);
		ext_inj_trig <= 1'b0;
		ext_reg_trig <= 1'b0;
	endtask

	task automatic wait_start();
		int i;
		for (i = 0; i < 300; i++) begin
			@(posedge mclk);
			#1;
			if (conv_start === 1'b1) break;
		end
		if (i == 300) chk("conv_start", 32'h0, 32'h1);
	endtask

	task automatic print_verdict();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// a hang counts as a mismatch
	initial begin
		#200000;
		n_errors++;
		print_verdict();
	end

	initial begin
		int i;
		int j;
		int p;
		int k;
		nrst = 1'b0;
		reg_addr = 6'h00;
		reg_wdata = 32'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		ext_reg_trig = 1'b0;
		ext_inj_trig = 1'b0;
		lvl = 12'h123;
		n_errors = 0;
		total_checks = 0;
		n_dma = 0;
		repeat (2) @(posedge mclk);
		nrst <= 1'b1;
		// reset values and an unmapped place
		rd(ADDR_WDLIM, rv);
		chk("limits", rv, {4'h0, WD_LOW_RST, 4'h0, WD_HIGH_RST});
		rd(ADDR_STS, rv);
		chk("status", rv, 32'h0);
		rd(6'h3C, rv);
		chk("unmapped", rv, 32'h0);
		// sequences written while idle
		wr(ADDR_SEQLEN, 32'h0);
		wr(ADDR_RSEQ_LO, 32'h5);
		wr(ADDR_JSEQ, 32'h3);
		wr(ADDR_JOFF_LO, 32'h200);
		c1 = '0;
		c1.reg_end_irq_en = 1'b1;
		c1.inj_end_irq_en = 1'b1;
		wr(ADDR_CTRL1, 32'(c1));
		c2 = '0;
		c2.on = 1'b1;
		c2.dma_req_en = 1'b1;
		wr(ADDR_CTRL2, 32'(c2));
		#1;
		chk("power", 32'(adc_power_on), 32'h1);
		repeat (20) @(posedge mclk);
		chk("power only", 32'(chq.size()), 32'h0);
		wr(ADDR_CTRL2, 32'(c2));
		wait_start();
		chk("channel", 32'(conv_channel), 32'h5);
		repeat (13) @(posedge mclk);
		#1;
		chk("early dma", 32'(dma_req), 32'h0);
		chk("early irq", 32'(reg_end_irq), 32'h0);
		@(posedge mclk);
		#1;
		chk("dma", 32'(dma_req), 32'h1);
		@(posedge mclk);
		#1;
		chk("reg irq", 32'(reg_end_irq), 32'h1);
		chk("dma pulse", 32'(dma_req), 32'h0);
		repeat (60) @(posedge mclk);
		chk("single", 32'(chq.size()), 32'h1);
		rd(ADDR_RDATA, rv);
		chk("right", rv, 32'h128);
		rd(ADDR_STS, rv);
		chk("sticky", rv, 32'h9);
		wr(ADDR_STS, 32'h7);
		rd(ADDR_STS, rv);
		chk("cleared", rv, 32'h8);
		repeat (2) @(posedge mclk);
		chk("irq low", 32'(reg_end_irq), 32'h0);
		// writing on again while powered starts, now left aligned
		c2.align_left = 1'b1;
		wr(ADDR_CTRL2, 32'(c2));
		wait_start();
		repeat (16) @(posedge mclk);
		rd(ADDR_RDATA, rv);
		chk("left", rv, 32'h1280);
		wr(ADDR_STS, 32'h7);
		// injected triggers, far apart, with continuous selected
		for (i = 0; i < 2; i++) begin
			c2 = '0;
			c2.on = 1'b1;
			c2.inj_trig_en = 1'b1;
			c2.continuous_select = 1'b1;
			c2.align_left = (i == 1);
			cfg2(c2);
			chq.delete();
			trig(1'b1);
			wait_start();
			chk("inj channel", 32'(conv_channel), 32'h3);
			repeat (16) @(posedge mclk);
			chk("inj irq", 32'(inj_end_irq), 32'h1);
			rd(ADDR_JDATA0, rv);
			ej = 16'sh0126 - 16'sh0200;
			chk("inj data", rv, {16'h0, (i == 1) ? ej <<< 3 : ej});
			repeat (60) @(posedge mclk);
			chk("inj once", 32'(chq.size()), 32'h1);
			wr(ADDR_STS, 32'h7);
		end
		// watchdog table, left aligned so limits must use raw values
		wr(ADDR_WDLIM, {4'h0, 12'h100, 4'h0, 12'h800});
		c2 = '0;
		c2.on = 1'b1;
		c2.align_left = 1'b1;
		cfg2(c2);
		for (j = 0; j < 6; j++) begin
			c1 = '0;
			c1.wd_irq_en = 1'b1;
			{c1.wd_single_channel, c1.wd_regular_en, c1.wd_channel_sel} = wc[j];
			wr(ADDR_CTRL1, 32'(c1));
			lvl <= wv[j] - 12'h5;
			wr(ADDR_CTRL2, 32'(c2));
			wait_start();
			repeat (16) @(posedge mclk);
			chk("wd irq", 32'(wd_irq), 32'(we[j]));
			rd(ADDR_STS, rv);
			chk("wd flag", 32'(rv[STS_WD]), 32'(we[j]));
			wr(ADDR_STS, 32'h7);
		end
		// continuous scan over three slots
		wr(ADDR_SEQLEN, 32'h2);
		wr(ADDR_RSEQ_LO, 32'h321);
		c1 = '0;
		c1.scan_en = 1'b1;
		wr(ADDR_CTRL1, 32'(c1));
		c2 = '0;
		c2.on = 1'b1;
		c2.continuous_select = 1'b1;
		c2.dma_req_en = 1'b1;
		cfg2(c2);
		chq.delete();
		n_dma = 0;
		wr(ADDR_CTRL2, 32'(c2));
		repeat (90) @(posedge mclk);
		wr(ADDR_CTRL2, 32'h0);
		chk("scan count", 32'(chq.size() >= 4), 32'h1);
		for (k = 0; k < 4; k++) begin
			chk("scan order", 32'(chq[k]), 32'(k % 3 + 1));
		end
		chk("scan dma", 32'(n_dma >= 3), 32'h1);
		// regular bursts of two over five slots, one group only
		wr(ADDR_SEQLEN, 32'h4);
		wr(ADDR_RSEQ_LO, 32'h76543);
		c1 = '0;
		c1.scan_en = 1'b1;
		c1.reg_discont_en = 1'b1;
		c1.discont_count = 3'h1;
		wr(ADDR_CTRL1, 32'(c1));
		c2 = '0;
		c2.on = 1'b1;
		c2.reg_trig_en = 1'b1;
		cfg2(c2);
		p = 0;
		for (i = 0; i < 4; i++) begin
			chq.delete();
			trig(1'b0);
			repeat (70) @(posedge mclk);
			k = (5 - p < 2) ? 5 - p : 2;
			chk("burst size", 32'(chq.size()), 32'(k));
			for (j = 0; j < k; j++) begin
				chk("burst slot", 32'(chq[j]), 32'(3 + p + j));
			end
			p = (p + k) % 5;
		end
		// auto injection appends injected slots, at both prescales
		wr(ADDR_SEQLEN, 32'h11);
		wr(ADDR_RSEQ_LO, 32'h21);
		wr(ADDR_JSEQ, 32'h43);
		c1 = '0;
		c1.scan_en = 1'b1;
		c1.auto_inject_en = 1'b1;
		wr(ADDR_CTRL1, 32'(c1));
		for (i = 0; i < 2; i++) begin
			c2 = '0;
			c2.on = 1'b1;
			c2.presc_long = (i == 1);
			cfg2(c2);
			chq.delete();
			tq.delete();
			wr(ADDR_CTRL2, 32'(c2));
			repeat (100) @(posedge mclk);
			chk_seq(20'h04321, 4);
			chk("gap", 32'(tq[2] - tq[1]), 32'(CONV_CYCLES) + 32'h1 +
				32'(i == 1 ? GAP_PRESC48 : GAP_PRESC2));
			rd(ADDR_JDATA1, rv);
			chk("auto inj data", rv, 32'(lvl + 12'h4));
		end
		// injected trigger pre-empts a regular scan, then holds one
		c1 = '0;
		c1.scan_en = 1'b1;
		wr(ADDR_CTRL1, 32'(c1));
		c2 = '0;
		c2.on = 1'b1;
		c2.inj_trig_en = 1'b1;
		c2.reg_trig_en = 1'b1;
		cfg2(c2);
		chq.delete();
		wr(ADDR_CTRL2, 32'(c2));
		wait_start();
		repeat (2) @(posedge mclk);
		trig(1'b1);
		repeat (100) @(posedge mclk);
		chk_seq(20'h21431, 5);
		chq.delete();
		trig(1'b1);
		trig(1'b0);
		repeat (100) @(posedge mclk);
		chk_seq(20'h02143, 4);
		// injected discontinuous: one slot per trigger, flag at the end
		c1 = '0;
		c1.scan_en = 1'b1;
		c1.inj_discont_en = 1'b1;
		wr(ADDR_CTRL1, 32'(c1));
		for (k = 0; k < 3; k++) begin
			wr(ADDR_STS, 32'h7);
			chq.delete();
			trig(1'b1);
			repeat (30) @(posedge mclk);
			chk_seq(20'(3 + k % 2), 1);
			rd(ADDR_STS, rv);
			chk("inj end", 32'(rv[STS_INJ_END]), 32'(k == 1));
		end
		print_verdict();
	end
endmodule
